// ---- hw/sosw_ctrl.sv ----
// Safety output start/restart control and field triple changeover
// Functional notes
// - Both safety outputs go OFF while the monitored protective field is violated.
// - Violation reaches OFF within the configured response time.
// - One resolution, 50 mm or 70 mm, held for the whole bank.
// - One maximum vehicle speed held for the whole bank.
// - One start-up behaviour selection for all fields together.
// - Automatic mode: outputs ON at power-up and when field clears.
// - Start interlock mode: OFF after power-up until reset; auto restart after.
// - Full interlock mode: OFF after power-up and after violation until reset.
// - Restart interlock always implies start interlock.
// - Valid reset press is held between 0.12 s and 4 s.
// - Two activation modes: fixed triple or signal selection with switchover time.
// - Fixed mode always monitors the first field triple.
// - Requested triple decoded only through configured control inputs.
// - Old triple stays monitored for 25 ms plus the switchover time during changeover.
// - Broken changeover rules raise a fault and force outputs OFF.
// - Timing violations force OFF and report a timing diagnostic.
// - Occupied new field trips after 25 ms plus switchover plus response time.
module sosw_ctrl
  import sosw_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] startup_mode_i,
  input wire logic resolution_sel_i,
  input wire logic [7:0] max_vehicle_speed_i,
  input wire logic [7:0] response_time_ms_i,
  input wire logic [7:0] switchover_time_ms_i,
  input wire logic activation_mode_i,
  input wire logic switch_monitor_en_i,
  input wire logic [31:0] triple_enabled_i,
  input wire logic [4:0] select_inputs_i,
  input wire logic [4:0] select_assign_i,
  input wire logic [31:0] field_violation_i,
  input wire logic reset_button_i,
  output logic safety_switching_output_a_o,
  output logic safety_switching_output_b_o,
  output logic start_restart_lockout_o,
  output logic fault_o,
  output logic [1:0] diag_code_o,
  output logic [4:0] active_triple_o,
  output logic changeover_busy_o,
  output logic resolution_o,
  output logic [7:0] max_vehicle_speed_o
);
  logic ms_tick;
  logic press_ok;

  sosw_tick_gen #(
    .CYCLES(MS_CYCLES_P)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(ms_tick)
  );

  sosw_press_qual u_press (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ms_tick_i(ms_tick),
    .btn_i(reset_button_i),
    .press_ok_o(press_ok)
  );

  // Bank settings caught once after reset; a live change cannot bypass interlocks
  logic cfg_loaded_q;
  sosw_mode_t mode_q;
  logic act_mode_q;
  logic [7:0] resp_ms_q;
  logic [7:0] switch_ms_q;
  // Start-up state, declared early: the changeover fault clear reads it
  sosw_state_t state_q;
  sosw_state_t state_d;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg_loaded_q <= 1'b0;
      mode_q <= SOSW_MODE_FULL_IL;
      act_mode_q <= ACT_FIXED;
      resp_ms_q <= '0;
      switch_ms_q <= '0;
      resolution_o <= RES_50MM;
      max_vehicle_speed_o <= '0;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      mode_q <= sosw_mode_t'(startup_mode_i);
      act_mode_q <= activation_mode_i;
      resp_ms_q <= response_time_ms_i;
      switch_ms_q <= switchover_time_ms_i;
      resolution_o <= resolution_sel_i;
      max_vehicle_speed_o <= max_vehicle_speed_i;
    end
  end

  // Requested triple: masked by configured inputs, or pinned in fixed mode
  logic [4:0] req_triple;
  assign req_triple = (act_mode_q == ACT_FIXED) ? FIRST_FIELD_TRIPLE
                      : (select_inputs_i & select_assign_i);

  // Changeover sequencing
  sosw_chg_t chg_q;
  logic [4:0] active_q;
  logic [4:0] pending_q;
  logic [11:0] chg_tmr_q;
  logic chg_fault_q;
  sosw_diag_t diag_q;
  logic activate;

  assign activate = (chg_q == SOSW_CHG_SWITCH) && (chg_tmr_q == 12'h000);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      chg_q <= SOSW_CHG_IDLE;
      active_q <= FIRST_FIELD_TRIPLE;
      pending_q <= FIRST_FIELD_TRIPLE;
      chg_tmr_q <= '0;
      chg_fault_q <= 1'b0;
      diag_q <= SOSW_DIAG_NONE;
    end else if (!cfg_loaded_q) begin
      chg_q <= SOSW_CHG_IDLE;
    end else begin
      if (press_ok && state_q == SOSW_ST_FAULT) begin
        chg_fault_q <= 1'b0;
        diag_q <= SOSW_DIAG_NONE;
      end
      case (chg_q)
        SOSW_CHG_IDLE: begin
          if (req_triple != active_q) begin
            if (switch_monitor_en_i && !triple_enabled_i[req_triple]) begin
              chg_fault_q <= 1'b1;
              diag_q <= SOSW_DIAG_BAD_TARGET;
            end else begin
              pending_q <= req_triple;
              chg_tmr_q <= SYNC_TICKS;
              chg_q <= SOSW_CHG_SYNC;
            end
          end
        end
        SOSW_CHG_SYNC, SOSW_CHG_SWITCH: begin
          if (req_triple != pending_q) begin
            // Selection moved mid-changeover: a timing fault
            chg_fault_q <= 1'b1;
            diag_q <= SOSW_DIAG_TIMING;
            chg_q <= SOSW_CHG_IDLE;
          end else if (chg_q == SOSW_CHG_SYNC && chg_tmr_q == 12'h000) begin
            chg_tmr_q <= {4'h0, switch_ms_q};
            chg_q <= SOSW_CHG_SWITCH;
          end else if (activate) begin
            active_q <= pending_q;
            chg_q <= SOSW_CHG_IDLE;
          end else if (ms_tick && chg_tmr_q != 12'h000) begin
            chg_tmr_q <= chg_tmr_q - 12'h001;
          end
        end
        default: begin
          chg_q <= SOSW_CHG_IDLE;
        end
      endcase
    end
  end

  // Violation filter: trips once the response time has run
  logic viol_now;
  logic [7:0] viol_ms_q;
  logic trip;

  assign viol_now = field_violation_i[active_q];
  assign trip = viol_now && (viol_ms_q >= resp_ms_q);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      viol_ms_q <= '0;
    end else if (!viol_now || activate) begin
      // New triple restarts the count, giving sync + switchover + response
      viol_ms_q <= '0;
    end else if (ms_tick && viol_ms_q != 8'hFF) begin
      viol_ms_q <= viol_ms_q + 8'h01;
    end
  end

  // Start-up / restart state machine
  logic full_il;

  // Reserved mode code is treated as the safest one
  assign full_il = (mode_q == SOSW_MODE_FULL_IL) || (mode_q == SOSW_MODE_RSVD);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SOSW_ST_LOCKED: begin
        if (press_ok && !viol_now) begin
          state_d = SOSW_ST_ON;
        end
      end
      SOSW_ST_ON: begin
        if (trip) begin
          state_d = full_il ? SOSW_ST_LOCKED : SOSW_ST_WAIT_CLEAR;
        end
      end
      SOSW_ST_WAIT_CLEAR: begin
        if (!viol_now) begin
          state_d = SOSW_ST_ON;
        end
      end
      SOSW_ST_FAULT: begin
        if (press_ok && !viol_now) begin
          state_d = SOSW_ST_ON;
        end
      end
      default: begin
        state_d = SOSW_ST_FAULT;
      end
    endcase
    if (chg_fault_q && state_q != SOSW_ST_FAULT) begin
      state_d = SOSW_ST_FAULT;
    end
    if (!cfg_loaded_q) begin
      state_d = SOSW_ST_LOCKED;
    end
  end

  logic first_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= SOSW_ST_LOCKED;
      first_q <= 1'b1;
    end else if (first_q && cfg_loaded_q) begin
      first_q <= 1'b0;
      // Power return: only automatic mode starts by itself
      if (mode_q == SOSW_MODE_AUTO) begin
        state_q <= SOSW_ST_WAIT_CLEAR;
      end else begin
        state_q <= SOSW_ST_LOCKED;
      end
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs from flops; both channels follow the same decision
  logic out_on;
  assign out_on = (state_d == SOSW_ST_ON) && !first_q && !trip && !chg_fault_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      safety_switching_output_a_o <= 1'b0;
      safety_switching_output_b_o <= 1'b0;
      start_restart_lockout_o <= 1'b1;
      fault_o <= 1'b0;
      diag_code_o <= SOSW_DIAG_NONE;
      active_triple_o <= FIRST_FIELD_TRIPLE;
      changeover_busy_o <= 1'b0;
    end else begin
      safety_switching_output_a_o <= out_on;
      safety_switching_output_b_o <= out_on;
      start_restart_lockout_o <= (state_d == SOSW_ST_LOCKED) || (state_d == SOSW_ST_FAULT);
      fault_o <= chg_fault_q;
      diag_code_o <= diag_q;
      active_triple_o <= active_q;
      changeover_busy_o <= (chg_q != SOSW_CHG_IDLE);
    end
  end

  AST_TRIP_OFF: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    trip |=> !safety_switching_output_a_o && !safety_switching_output_b_o)
    else $error("outputs on after trip");
  AST_CHANNELS_EQUAL: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    safety_switching_output_a_o == safety_switching_output_b_o)
    else $error("output channels differ");
  AST_FAULT_OFF: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    chg_fault_q |=> !safety_switching_output_a_o)
    else $error("outputs on during changeover fault");
  AST_FIXED_FIRST: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cfg_loaded_q && act_mode_q == ACT_FIXED) |-> active_q == FIRST_FIELD_TRIPLE)
    else $error("fixed mode left first triple");
  AST_FULL_RELOCK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == SOSW_ST_ON && trip && full_il && !chg_fault_q)
    |=> state_q == SOSW_ST_LOCKED)
    else $error("full interlock did not relock");
  // Outputs follow the next state, so the restart shows one edge later
  AST_AUTO_RESTART: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == SOSW_ST_WAIT_CLEAR && !viol_now && !chg_fault_q)
    |=> safety_switching_output_a_o)
    else $error("automatic restart missing");
  AST_LOCK_NEEDS_PRESS: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == SOSW_ST_LOCKED && !press_ok) |=> state_q != SOSW_ST_ON)
    else $error("unlock without valid press");
  AST_OLD_TRIPLE_HELD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (chg_q == SOSW_CHG_SYNC) |=> $stable(active_q))
    else $error("triple switched during sync");
  // Covers both sync and switch phases
  AST_TIMING_DIAG: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (chg_q != SOSW_CHG_IDLE && req_triple != pending_q)
    |=> ##1 diag_code_o == SOSW_DIAG_TIMING && fault_o)
    else $error("timing fault not reported");
  AST_START_LOCK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (first_q && cfg_loaded_q && mode_q != SOSW_MODE_AUTO)
    |=> state_q == SOSW_ST_LOCKED)
    else $error("start interlock missing");
endmodule : sosw_ctrl

// ---- hw/sosw_pkg.sv ----
// Constants and types for the safety output restart and field switch block
package sosw_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned TICK_CW = 18;
  // Times in milliseconds as specified
  localparam int unsigned SYNC_TIME_MS = 25;
  localparam int unsigned PRESS_MIN_MS = 120;
  localparam int unsigned PRESS_MAX_MS = 4000;
  // Tick counts; whole ticks only, so bounds are made strict
  localparam logic [11:0] SYNC_TICKS = 12'(SYNC_TIME_MS);
  localparam logic [11:0] PRESS_MIN_TICKS = 12'(PRESS_MIN_MS + 1);
  localparam logic [11:0] PRESS_MAX_TICKS = 12'(PRESS_MAX_MS - 1);
  localparam logic [11:0] TICKS_MAX = 12'hFFF;
  // Field triples
  localparam int unsigned TRIPLE_W = 5;
  localparam int unsigned TRIPLE_N = 32;
  localparam logic [4:0] FIRST_FIELD_TRIPLE = 5'h00;
  // Resolution encoding
  localparam logic RES_50MM = 1'b0;
  localparam logic RES_70MM = 1'b1;
  // Field activation modes
  localparam logic ACT_FIXED = 1'b0;
  localparam logic ACT_SIGNAL = 1'b1;

  typedef enum logic [1:0] {
    SOSW_MODE_AUTO = 2'b00,
    SOSW_MODE_START_IL = 2'b01,
    SOSW_MODE_FULL_IL = 2'b10,
    SOSW_MODE_RSVD = 2'b11
  } sosw_mode_t;

  typedef enum logic [1:0] {
    SOSW_ST_LOCKED = 2'b00,
    SOSW_ST_ON = 2'b01,
    SOSW_ST_WAIT_CLEAR = 2'b10,
    SOSW_ST_FAULT = 2'b11
  } sosw_state_t;

  typedef enum logic [1:0] {
    SOSW_CHG_IDLE = 2'b00,
    SOSW_CHG_SYNC = 2'b01,
    SOSW_CHG_SWITCH = 2'b10
  } sosw_chg_t;

  typedef enum logic [1:0] {
    SOSW_DIAG_NONE = 2'b00,
    SOSW_DIAG_BAD_TARGET = 2'b01,
    SOSW_DIAG_TIMING = 2'b10
  } sosw_diag_t;
endpackage : sosw_pkg

// ---- hw/sosw_tick_gen.sv ----
// Millisecond tick generator
module sosw_tick_gen
  import sosw_pkg::*;
#(
  parameter int unsigned CYCLES = MS_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  output logic tick_o
);
  logic [TICK_CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == TICK_CW'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + TICK_CW'(1);
      tick_o <= 1'b0;
    end
  end
endmodule : sosw_tick_gen

// ---- hw/sosw_press_qual.sv ----
// Reset button press duration qualifier
module sosw_press_qual
  import sosw_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ms_tick_i,
  input wire logic btn_i,
  output logic press_ok_o
);
  logic btn_q;
  logic [11:0] held_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      btn_q <= 1'b0;
      held_q <= '0;
      press_ok_o <= 1'b0;
    end else begin
      btn_q <= btn_i;
      // Accept only on release, within both bounds; others are dropped
      press_ok_o <= btn_q && !btn_i && (held_q >= PRESS_MIN_TICKS)
                    && (held_q <= PRESS_MAX_TICKS);
      if (!btn_i) begin
        held_q <= '0;
      end else if (ms_tick_i && held_q != TICKS_MAX) begin
        held_q <= held_q + 12'h001;
      end
    end
  end

  AST_SHORT_PRESS_IGNORED: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (btn_q && !btn_i && held_q < PRESS_MIN_TICKS) |=> !press_ok_o)
    else $error("short press accepted");
  AST_LONG_PRESS_IGNORED: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (btn_q && !btn_i && held_q > PRESS_MAX_TICKS) |=> !press_ok_o)
    else $error("long press accepted");
endmodule : sosw_press_qual

// ---- sim/sosw_far_model.sv ----
// Far side model: machine control selection lines and operator button
module sosw_far_model (
  input wire logic clk_sys_i,
  output logic reset_button_o,
  output logic [4:0] select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reset_button_o = 1'b0;
    select_o = 5'h00;
  end
  // Whole cycles; always released afterwards so presses stay apart
  task automatic press(input int cycles);
    @(posedge clk_sys_i);
    #1 reset_button_o = 1'b1;
    repeat (cycles) @(posedge clk_sys_i);
    #1 reset_button_o = 1'b0;
  endtask : press
  // Targets are chosen by the bench; only the fault tests ask for bad ones
  task automatic pick(input logic [4:0] t);
    @(posedge clk_sys_i);
    #1 select_o = t;
  endtask : pick
endmodule : sosw_far_model

// ---- sim/testbench.sv ----
// Self-checking bench for the restart and field switch control
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sosw_pkg::*;
  localparam int TC = 4;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] startup_mode_i = 2'h0;
  logic resolution_sel_i = 1'b0;
  logic [7:0] max_vehicle_speed_i = 8'h00;
  logic [7:0] response_time_ms_i = 8'h00;
  logic [7:0] switchover_time_ms_i = 8'h01;
  logic activation_mode_i = 1'b0;
  logic switch_monitor_en_i = 1'b0;
  logic [31:0] triple_enabled_i = 32'hFFFFFFFF;
  logic [4:0] select_inputs_i;
  logic [4:0] select_assign_i = 5'h1F;
  logic [31:0] field_violation_i = 32'h00000000;
  logic reset_button_i;
  logic safety_switching_output_a_o, safety_switching_output_b_o;
  logic start_restart_lockout_o, fault_o, changeover_busy_o, resolution_o;
  logic [1:0] diag_code_o;
  logic [4:0] active_triple_o;
  logic [7:0] max_vehicle_speed_o;
  logic [31:0] lfsr_state = 32'h000164EC;
  int err_total = 0;
  int cmp_count = 0;
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  sosw_ctrl #(.MS_CYCLES_P(TC)) sosw_ctrl_i (
    .clk_sys_i, .sys_rst_i, .startup_mode_i, .resolution_sel_i, .max_vehicle_speed_i,
    .response_time_ms_i, .switchover_time_ms_i, .activation_mode_i, .switch_monitor_en_i,
    .triple_enabled_i, .select_inputs_i, .select_assign_i, .field_violation_i,
    .reset_button_i, .safety_switching_output_a_o, .safety_switching_output_b_o,
    .start_restart_lockout_o, .fault_o, .diag_code_o, .active_triple_o,
    .changeover_busy_o, .resolution_o, .max_vehicle_speed_o
  );
  sosw_far_model sosw_far_model_i (
    .clk_sys_i,
    .reset_button_o(reset_button_i),
    .select_o(select_inputs_i)
  );
  function automatic logic [7:0] rnd();
    lfsr_state = {lfsr_state[30:0],
                  lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state[7:0];
  endfunction : rnd
  function automatic logic [4:0] exp_triple(input logic [4:0] i, input logic [4:0] m,
                                            input logic act);
    return act ? (i & m) : 5'h00;
  endfunction : exp_triple
  function automatic logic exp_restart(input int m);
    return m < 2;
  endfunction : exp_restart
  function automatic int sw_cycles(input int s);
    return (SYNC_TIME_MS + s) * TC;
  endfunction : sw_cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic chk_bit(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit
  task automatic chk_vec(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_vec
  // Bounded wait for output A to reach a level, then both outputs are checked
  task automatic wait_out(input logic e, input int lim);
    int k;
    for (k = 0; k < lim && safety_switching_output_a_o !== e; k++) cyc(1);
    chk_bit("output_a", e, safety_switching_output_a_o);
    chk_bit("output_b", e, safety_switching_output_b_o);
  endtask : wait_out
  task automatic do_reset(input logic [1:0] m, input logic act);
    sys_rst_i = 1'b1;
    startup_mode_i = m;
    activation_mode_i = act;
    resolution_sel_i = rnd() > 8'h7F;
    max_vehicle_speed_i = rnd();
    response_time_ms_i = rnd() & 8'h03;
    switchover_time_ms_i = (rnd() & 8'h07) + 8'h01;
    field_violation_i = 32'h00000000;
    cyc(6);
    chk_bit("rst_lockout", 1'b1, start_restart_lockout_o);
    sys_rst_i = 1'b0;
    cyc(3);
    chk_bit("resolution", resolution_sel_i, resolution_o);
    chk_vec("speed", max_vehicle_speed_i, max_vehicle_speed_o);
  endtask : do_reset
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Whole run is near 40k cycles; give up at 60k
  initial begin
    #240000;
    err_total++;
    report_and_stop();
  end
  initial begin : main
    int m;
    int r;
    int s;
    logic [4:0] t;
    do_reset(2'h0, ACT_FIXED);
    r = response_time_ms_i;
    wait_out(1'b1, 20);
    sosw_far_model_i.pick(5'h13);
    cyc(8);
    chk_vec("fixed_triple", 8'(exp_triple(5'h13, 5'h1F, 1'b0)), 8'(active_triple_o));
    field_violation_i = 32'h00000001;
    wait_out(1'b0, r * TC + 12);
    field_violation_i = 32'h00000000;
    wait_out(1'b1, 20);
    $display("test automatic done");
    for (m = 1; m < 4; m++) begin
      do_reset(2'(m), ACT_FIXED);
      r = response_time_ms_i;
      cyc(10);
      chk_bit("lockout", 1'b1, start_restart_lockout_o);
      chk_bit("start_off", 1'b0, safety_switching_output_a_o);
      sosw_far_model_i.press(50 * TC);
      cyc(20);
      chk_bit("short_press", 1'b0, safety_switching_output_a_o);
      if (m == 2) begin
        sosw_far_model_i.press(4010 * TC);
        cyc(20);
        chk_bit("long_press", 1'b0, safety_switching_output_a_o);
      end
      sosw_far_model_i.press((m == 3 ? 3990 : 130) * TC);
      wait_out(1'b1, 20);
      field_violation_i = 32'h00000001;
      wait_out(1'b0, r * TC + 12);
      field_violation_i = 32'h00000000;
      cyc(30);
      chk_bit("restart", exp_restart(m), safety_switching_output_a_o);
      sosw_far_model_i.press(200 * TC);
      wait_out(1'b1, 20);
      $display("test interlock mode %0d done", m);
    end
    sosw_far_model_i.pick(5'h00);
    select_assign_i = 5'h0F;
    do_reset(2'h0, ACT_SIGNAL);
    r = response_time_ms_i;
    s = switchover_time_ms_i;
    wait_out(1'b1, 20);
    // Target kept above 8 so the later picks of 3 and 5 always differ from it
    t = 5'(rnd()) | 5'h19;
    sosw_far_model_i.pick(t);
    field_violation_i = 32'h00000001 << exp_triple(t, 5'h0F, 1'b1);
    cyc(3);
    chk_bit("busy", 1'b1, changeover_busy_o);
    cyc(sw_cycles(s) - 16);
    chk_vec("old_triple", 8'h00, 8'(active_triple_o));
    chk_bit("still_on", 1'b1, safety_switching_output_a_o);
    wait_out(1'b0, (r + 2) * TC + 24);
    chk_vec("new_triple", 8'(exp_triple(t, 5'h0F, 1'b1)), 8'(active_triple_o));
    field_violation_i = 32'h00000000;
    wait_out(1'b1, 20);
    $display("test changeover done");
    sosw_far_model_i.pick(5'h03);
    cyc(10);
    sosw_far_model_i.pick(5'h05);
    wait_out(1'b0, 40);
    cyc(2);
    chk_bit("fault", 1'b1, fault_o);
    chk_vec("diag", 8'(SOSW_DIAG_TIMING), 8'(diag_code_o));
    sosw_far_model_i.press(200 * TC);
    cyc(30);
    chk_bit("fault_clear", 1'b0, fault_o);
    cyc(sw_cycles(8) + 40);
    triple_enabled_i = 32'hFFFFFDFF;
    switch_monitor_en_i = 1'b1;
    sosw_far_model_i.pick(5'h09);
    cyc(10);
    chk_bit("target_fault", 1'b1, fault_o);
    chk_vec("target_diag", 8'(SOSW_DIAG_BAD_TARGET), 8'(diag_code_o));
    chk_bit("target_off", 1'b0, safety_switching_output_a_o);
    $display("test changeover faults done");
    report_and_stop();
  end
endmodule : testbench
